// >>> verilog/cbfe_event_logic.sv
// Card-mode function event, mask, present-state and force-event registers.
// Assumes classic Wishbone master on the same clock; bus reset pin is async.
// Notes on behaviour
// - Forcing the interrupt field sets interrupt flag bit 15 of the event register.
// - Writing one to an event flag clears it and writing zero leaves it alone.
// - The interrupt flag survives the bus reset pin.
// - A zero-to-one change of the present general wakeup bit sets event bit 4.
// - Forcing the general wakeup field also sets event bit 4.
// - Wakeup event flag, interrupt mask, wakeup mask and wakeup-event mask survive bus reset.
// - Event and mask registers work only while card mode and function registers are enabled.
// - With interrupt mask clear, interrupt flags drive neither the line nor the wakeup pin.
// - With interrupt mask set, interrupt flags drive the line when powered up and, with wakeup mask, wake when powered off.
// - With wakeup mask clear, no event flag raises the status-change pin.
// - The wakeup event flag raises the pin only when its mask and wakeup mask are set.
// - The status-change pin is active high and otherwise behaves as a wake event pin.
// - General wakeup bits across the registers stand for the signalled wake event; interrupt bits stand for the interrupt status.
// - Present interrupt bit is one while any interrupt status bit is set.
// - Present wakeup bit follows the wake status and stays until that status clears.
// - Forcing sets the event flag without touching the present bit; zero does nothing.
`timescale 1ns/1ps
module cbfe_event_logic #(
  parameter int ISR_WIDTH = cbfe_pkg::ISR_W
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  // Wishbone slave
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [cbfe_pkg::ADDR_W-1:0]  adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  // Device state
  input  wire logic [ISR_WIDTH-1:0]         isrBits,
  input  wire logic                         pmeStatus,
  input  wire logic                         poweredUp,
  input  wire logic                         busResetPinN,
  // Pins
  output logic                              intLineN,
  output logic                              statusChangeWake
);
  import cbfe_pkg::*;

  // Parameter check
  if (ISR_WIDTH < 1 || ISR_WIDTH > 32)
  begin : g_bad_width
    $error("ISR_WIDTH must lie between 1 and 32");
  end

  typedef struct packed {
    logic        busSync1;
    logic        busSync2;
    logic        ack;
    logic [31:0] rdat;
    logic        cardEn;
    logic        funcEn;
    logic        presIntr;
    logic        presGwake;
    logic        presGwakePrev;
    logic        evIntr;
    logic        evGwake;
    logic        mkIntr;
    logic        mkWkup;
    logic        mkGwake;
  } cbfe_state_t;

  cbfe_state_t q;
  cbfe_state_t d;
  logic        accept;
  logic        wr;
  logic        en;
  logic        gwakeRise;
  logic        clrIntr;
  logic        clrGwake;
  logic        forceIntr;
  logic        forceGwake;
  logic        busReset;

  cbfe_gate_if gate ();

  // Word decode of a byte offset
  function automatic logic hit(input logic [ADDR_W-1:0] adr,
                               input logic [ADDR_W-1:0] ofs);
    hit = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // Write strobe for one bit within its byte lane
  function automatic logic bitOne(input logic [3:0]  sel,
                                  input logic [31:0] dat,
                                  input int          lane,
                                  input int          pos);
    bitOne = sel[lane] & dat[pos];
  endfunction

  // Read data for the addressed word
  function automatic logic [31:0] readWord(input logic [ADDR_W-1:0] adr,
                                           input cbfe_state_t s,
                                           input logic en_);
    logic [31:0] w;
    w = WORD_ZERO;
    if (hit(adr, OFS_CONFIG))
    begin
      w[CARD_EN_BIT] = s.cardEn;
      w[FUNC_EN_BIT] = s.funcEn;
    end
    else if (en_ && hit(adr, OFS_EVENT))
    begin
      w[FUNCTION_INTERRUPT_FLAG_BIT]  = s.evIntr;
      w[GENERAL_WAKEUP_FLAG_BIT] = s.evGwake;
    end
    else if (en_ && hit(adr, OFS_MASK))
    begin
      w[FUNCTION_INTERRUPT_FLAG_BIT]  = s.mkIntr;
      w[WAKEUP_PIN_MASK_BIT]  = s.mkWkup;
      w[GENERAL_WAKEUP_FLAG_BIT] = s.mkGwake;
    end
    else if (en_ && hit(adr, OFS_PRESENT))
    begin
      w[FUNCTION_INTERRUPT_FLAG_BIT]  = s.presIntr;
      w[GENERAL_WAKEUP_FLAG_BIT] = s.presGwake;
    end
    readWord = w;
  endfunction

  // Bus request decode, one ack per request
  assign accept   = cyc_i & stb_i & ~q.ack;
  assign wr       = accept & we_i;
  assign en       = q.cardEn & q.funcEn;
  assign busReset = ~q.busSync2;

  // Event sources, only while enabled
  assign gwakeRise  = en & q.presGwake & ~q.presGwakePrev;
  assign clrIntr    = en & wr & hit(adr_i, OFS_EVENT)
                      & bitOne(sel_i, dat_i, LANE_HIGH, FUNCTION_INTERRUPT_FLAG_BIT);
  assign clrGwake   = en & wr & hit(adr_i, OFS_EVENT)
                      & bitOne(sel_i, dat_i, LANE_LOW, GENERAL_WAKEUP_FLAG_BIT);
  assign forceIntr  = en & wr & hit(adr_i, OFS_FORCE)
                      & bitOne(sel_i, dat_i, LANE_HIGH, FUNCTION_INTERRUPT_FLAG_BIT);
  assign forceGwake = en & wr & hit(adr_i, OFS_FORCE)
                      & bitOne(sel_i, dat_i, LANE_LOW, GENERAL_WAKEUP_FLAG_BIT);

  // Next state
  always_comb
  begin
    d = q;
    // Bus reset pin synchroniser
    d.busSync1 = busResetPinN;
    d.busSync2 = q.busSync1;
    // Bus answer, unmapped words read zero
    d.ack  = accept;
    d.rdat = accept ? readWord(adr_i, q, en) : WORD_ZERO;
    // Present state tracks device status only
    d.presIntr      = |isrBits;
    d.presGwake     = pmeStatus;
    d.presGwakePrev = q.presGwake;
    // Event flags, set wins over clear
    if (clrIntr)
    begin
      d.evIntr = FLAG_RST;
    end
    if (forceIntr)
    begin
      d.evIntr = 1'b1;
    end
    if (clrGwake)
    begin
      d.evGwake = FLAG_RST;
    end
    if (forceGwake || gwakeRise)
    begin
      d.evGwake = 1'b1;
    end
    // Mask register, reserved bits dropped
    if (en && wr && hit(adr_i, OFS_MASK))
    begin
      if (sel_i[LANE_HIGH])
      begin
        d.mkIntr = dat_i[FUNCTION_INTERRUPT_FLAG_BIT];
        d.mkWkup = dat_i[WAKEUP_PIN_MASK_BIT];
      end
      if (sel_i[LANE_LOW])
      begin
        d.mkGwake = dat_i[GENERAL_WAKEUP_FLAG_BIT];
      end
    end
    // Enable bits of the third configuration register
    if (wr && hit(adr_i, OFS_CONFIG) && sel_i[LANE_LOW])
    begin
      d.cardEn = dat_i[CARD_EN_BIT];
      d.funcEn = dat_i[FUNC_EN_BIT];
    end
    // Bus reset touches only the enables; flags and masks survive
    if (busReset)
    begin
      d.cardEn = CFG_RST;
      d.funcEn = CFG_RST;
    end
    // Power-on reset
    if (!rst_n)
    begin
      d          = '0;
      d.evIntr   = FLAG_RST;
      d.evGwake  = FLAG_RST;
      d.mkIntr   = MASK_RST;
      d.mkWkup   = MASK_RST;
      d.mkGwake  = MASK_RST;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    q <= d;
  end

  // Flags and masks to the pin gate
  assign gate.enable      = en;
  assign gate.poweredUp   = poweredUp;
  assign gate.presentIntr = q.presIntr;
  assign gate.eventIntr   = q.evIntr;
  assign gate.eventGwake  = q.evGwake;
  assign gate.maskIntr    = q.mkIntr;
  assign gate.maskWkup    = q.mkWkup;
  assign gate.maskGwake   = q.mkGwake;

  // Pin gate
  cbfe_pin_gate u_gate (
    .clock (clock),
    .rst_n (rst_n),
    .g     (gate.gate)
  );

  // Outputs straight from flops
  assign dat_o            = q.rdat;
  assign ack_o            = q.ack;
  assign intLineN         = gate.intLineN;
  assign statusChangeWake = gate.wakePin;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_force_sets_function_interrupt_flag: assert property (forceIntr |=> q.evIntr)
    else $error("forced interrupt did not set the event flag");
  a_write_one_clear: assert property (
    clrIntr && !forceIntr |=> !q.evIntr)
    else $error("write one did not clear the interrupt flag");
  a_write_zero_keep: assert property (
    en && wr && hit(adr_i, OFS_EVENT) && !dat_i[FUNCTION_INTERRUPT_FLAG_BIT] && !dat_i[GENERAL_WAKEUP_FLAG_BIT]
    && !gwakeRise |=> $stable(q.evIntr) && $stable(q.evGwake))
    else $error("write zero changed an event flag");
  a_bus_reset_hold: assert property (
    busReset && !wr && !gwakeRise
    |=> $stable(q.evIntr) && $stable(q.evGwake) && $stable(q.mkIntr))
    else $error("bus reset disturbed a sticky bit");
  a_mask_bus_reset: assert property (
    busReset && !wr |=> $stable(q.mkWkup) && $stable(q.mkGwake))
    else $error("bus reset disturbed a mask bit");
  a_general_wakeup_flag_rise_set: assert property (gwakeRise |=> q.evGwake)
    else $error("wakeup rise did not set the event flag");
  a_force_general_wakeup_flag_set: assert property (forceGwake |=> q.evGwake)
    else $error("forced wakeup did not set the event flag");
  a_disabled_frozen: assert property (
    !en |=> $stable(q.evIntr) && $stable(q.mkIntr) && $stable(q.mkWkup))
    else $error("event or mask changed while disabled");
  a_present_follow: assert property (
    ##1 q.presIntr == |$past(isrBits))
    else $error("present interrupt bit does not follow status");
  a_force_no_present: assert property (
    forceIntr && !(|isrBits) |=> !q.presIntr)
    else $error("force changed the present interrupt bit");
  a_reserved_zero: assert property (
    ack_o |-> dat_o[31:16] == 16'h0000 && dat_o[13:5] == 9'h000)
    else $error("reserved read bits not zero");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // Further checks on wake status, gating and the bus answer
  a_present_general_wakeup_flag: assert property (
    ##1 q.presGwake == $past(pmeStatus))
    else $error("present wakeup bit does not follow wake status");
  a_disabled_pins: assert property (
    !en |=> intLineN && !statusChangeWake)
    else $error("pins active while registers disabled");
  a_clear_general_wakeup_flag: assert property (
    clrGwake && !forceGwake && !gwakeRise |=> !q.evGwake)
    else $error("write one did not clear the wakeup flag");
  a_mask_write: assert property (
    en && wr && hit(adr_i, OFS_MASK) && sel_i[LANE_HIGH]
    |=> q.mkIntr == $past(dat_i[FUNCTION_INTERRUPT_FLAG_BIT]))
    else $error("enabled mask write did not land");
  a_ack_after_take: assert property (accept |=> ack_o)
    else $error("taken request not acknowledged next cycle");
  a_idle_read_zero: assert property (!ack_o |-> dat_o == WORD_ZERO)
    else $error("read data not zero outside ack");
  a_bus_reset_enables: assert property (
    busReset |=> !q.cardEn && !q.funcEn)
    else $error("bus reset did not clear the enables");

  c_force_then_clear: cover property (forceIntr ##[1:20] clrIntr);
  c_general_wakeup_flag_rise: cover property (gwakeRise);
  c_bus_reset_keep: cover property (busReset && q.evGwake);
endmodule // cbfe_event_logic

// >>> verilog/cbfe_pkg.sv
// Package for the card-mode function event logic.
// Assumes a Wishbone slave with a 9-bit byte address and 32-bit data.
package cbfe_pkg;

  // Register byte offsets
  localparam int              ADDR_W      = 9;
  localparam logic [8:0]      OFS_EVENT   = 9'h0F0;
  localparam logic [8:0]      OFS_MASK    = 9'h0F4;
  localparam logic [8:0]      OFS_PRESENT = 9'h0F8;
  localparam logic [8:0]      OFS_FORCE   = 9'h0FC;
  localparam logic [8:0]      OFS_CONFIG  = 9'h100;

  // Field positions
  localparam int              FUNCTION_INTERRUPT_FLAG_BIT    = 15;
  localparam int              WAKEUP_PIN_MASK_BIT    = 14;
  localparam int              GENERAL_WAKEUP_FLAG_BIT   = 4;
  localparam int              CARD_EN_BIT = 3;
  localparam int              FUNC_EN_BIT = 1;

  // Byte lanes that carry the fields
  localparam int              LANE_HIGH   = 1;
  localparam int              LANE_LOW    = 0;

  // Widths and reset values
  localparam int              ISR_W       = 16;
  localparam logic            FLAG_RST    = 1'b0;
  localparam logic            MASK_RST    = 1'b0;
  localparam logic            CFG_RST     = 1'b0;
  localparam logic [31:0]     WORD_ZERO   = 32'h0000_0000;

endpackage : cbfe_pkg

// >>> verilog/cbfe_gate_if.sv
// Interface between the register core and the pin gate.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cbfe_gate_if;
  logic enable;
  logic poweredUp;
  logic presentIntr;
  logic eventIntr;
  logic eventGwake;
  logic maskIntr;
  logic maskWkup;
  logic maskGwake;
  logic intLineN;
  logic wakePin;

  // Register core side
  modport core (
    output enable, poweredUp, presentIntr, eventIntr, eventGwake,
    output maskIntr, maskWkup, maskGwake,
    input  intLineN, wakePin
  );

  // Pin gate side
  modport gate (
    input  enable, poweredUp, presentIntr, eventIntr, eventGwake,
    input  maskIntr, maskWkup, maskGwake,
    output intLineN, wakePin
  );
endinterface : cbfe_gate_if

// >>> verilog/cbfe_pin_gate.sv
// Pin gate: masks flags onto the interrupt line and the wakeup pin.
// Assumes all interface inputs come from flops on the same clock.
`timescale 1ns/1ps
module cbfe_pin_gate (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Flags and masks in, pins out
  cbfe_gate_if.gate  g
);
  import cbfe_pkg::*;

  typedef struct packed {
    logic lineN;
    logic wake;
  } cbfe_gate_state_t;

  cbfe_gate_state_t q;
  cbfe_gate_state_t d;
  logic             intrOn;

  // Masked interrupt source, present state or event flag
  assign intrOn = g.maskIntr & (g.presentIntr | g.eventIntr);

  // Next pin levels
  always_comb
  begin
    d = q;
    d.lineN = ~(g.enable & g.poweredUp & intrOn);
    // Wake needs the wakeup mask; interrupt wakes only when powered off
    d.wake = g.enable & g.maskWkup & ((~g.poweredUp & intrOn)
             | (g.maskGwake & g.eventGwake));
    if (!rst_n)
    begin
      d       = '0;
      d.lineN = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    q <= d;
  end

  // Interrupt line is active low, wakeup pin active high
  assign g.intLineN = q.lineN;
  assign g.wakePin  = q.wake;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_int_masked_off: assert property (!g.maskIntr |=> g.intLineN)
    else $error("interrupt line asserted with interrupt mask clear");
  a_int_line_on: assert property (
    g.enable && g.poweredUp && g.maskIntr && (g.presentIntr || g.eventIntr)
    |=> !g.intLineN)
    else $error("masked-in interrupt did not assert the line");
  a_wake_needs_wakeup_pin_mask: assert property (!g.maskWkup |=> !g.wakePin)
    else $error("wakeup pin asserted with wakeup mask clear");
  a_general_wakeup_flag_wake_pin: assert property (
    g.enable && g.maskWkup && g.maskGwake && g.eventGwake |=> g.wakePin)
    else $error("general wakeup flag did not raise the wakeup pin");
  a_function_interrupt_flag_wake_off: assert property (
    g.enable && !g.poweredUp && g.maskIntr && g.maskWkup && g.eventIntr
    |=> g.wakePin)
    else $error("interrupt did not wake while powered off");

  c_wake_pin_rise: cover property (!g.wakePin ##1 g.wakePin);
  c_int_line_fall: cover property (g.intLineN ##1 !g.intLineN);
endmodule // cbfe_pin_gate

// >>> sim/cbfe_host_model.sv
// Host side model: drives the bus reset pin and card power state.
// Assumes the bench clock; requests arrive as levels from the bench.
`timescale 1ns/1ps
module cbfe_host_model #(
  parameter int RST_CYCLES = 4
) (
  // Clock and bench requests
  input  wire logic clock,
  input  wire logic resetReq,
  input  wire logic powerReq,
  // Lines toward the card
  output logic      busResetPinN,
  output logic      poweredUp
);
  logic [7:0] cnt_q = 8'h00;

  // Hold the reset pin low for a fixed span after a request
  always @(posedge clock)
  begin
    if (resetReq)
      cnt_q <= 8'(RST_CYCLES);
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  // Pin levels seen by the card
  assign busResetPinN = (cnt_q == 8'h00);
  assign poweredUp    = powerReq;
endmodule // cbfe_host_model

// >>> sim/tb_cardbus_function_event_logic.sv
// Self-checking bench for the card-mode function event logic.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_cardbus_function_event_logic;
  import cbfe_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, datO;
  logic [15:0] interrupt_status_register = 16'h0000;
  logic        ack, intLineN, wake, busRstN, powered;
  logic        pme = 1'b0, rstReq = 1'b0, pwrReq = 1'b1;
  int          n_mismatch = 0, n_compared = 0;

  // Bench clock
  always #20 clock = ~clock;

  cbfe_event_logic DUT (.clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(datO), .ack_o(ack),
    .isrBits(interrupt_status_register), .pmeStatus(pme), .poweredUp(powered), .busResetPinN(busRstN),
    .intLineN(intLineN), .statusChangeWake(wake));

  cbfe_host_model host (.clock(clock), .resetReq(rstReq), .powerReq(pwrReq),
    .busResetPinN(busRstN), .poweredUp(powered));

  // Verdict and end of run
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One classic bus cycle, waits for ack; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Enable gating and reserved bits
  task automatic t_enable();
    wb(1'b1, OFS_MASK, 32'h0000_C010);
    wb(1'b1, OFS_CONFIG, 32'h0000_000A);
    rd(OFS_MASK, 32'h0000_0000);
    wb(1'b1, OFS_MASK, 32'hFFFF_FFFF);
    rd(OFS_MASK, 32'h0000_C010);
    wb(1'b1, OFS_MASK, 32'h0000_0000);
  endtask

  // Forced interrupt flag, masking and write-one clear
  task automatic t_function_interrupt_flag();
    wb(1'b1, OFS_FORCE, 32'h0000_8000);
    rd(OFS_EVENT, 32'h0000_8000);
    rd(OFS_PRESENT, 32'h0000_0000);
    wt(4);
    `CHK(intLineN, 1'b1)
    wb(1'b1, OFS_MASK, 32'h0000_8000);
    wt(4);
    `CHK(intLineN, 1'b0)
    `CHK(wake, 1'b0)
    wb(1'b1, OFS_EVENT, 32'h0000_0000);
    rd(OFS_EVENT, 32'h0000_8000);
    wb(1'b1, OFS_EVENT, 32'h0000_8000);
    rd(OFS_EVENT, 32'h0000_0000);
    wt(4);
    `CHK(intLineN, 1'b1)
  endtask

  // Wakeup rise, wake pin masks and forced wakeup
  task automatic t_general_wakeup_flag();
    wb(1'b1, OFS_MASK, 32'h0000_0010);
    pme <= 1'b1;
    wt(5);
    rd(OFS_EVENT, 32'h0000_0010);
    rd(OFS_PRESENT, 32'h0000_0010);
    `CHK(wake, 1'b0)
    wb(1'b1, OFS_MASK, 32'h0000_4010);
    wt(4);
    `CHK(wake, 1'b1)
    wb(1'b1, OFS_MASK, 32'h0000_4000);
    wt(4);
    `CHK(wake, 1'b0)
    pme <= 1'b0;
    wb(1'b1, OFS_EVENT, 32'h0000_0010);
    rd(OFS_EVENT, 32'h0000_0000);
    wb(1'b1, OFS_FORCE, 32'h0000_0010);
    rd(OFS_EVENT, 32'h0000_0010);
    rd(OFS_PRESENT, 32'h0000_0000);
    wb(1'b1, OFS_EVENT, 32'h0000_0010);
  endtask

  // Present interrupt bit follows status bits
  task automatic t_present();
    interrupt_status_register <= 16'h0100;
    wt(3);
    rd(OFS_PRESENT, 32'h0000_8000);
    interrupt_status_register <= 16'h0000;
    wt(3);
    rd(OFS_PRESENT, 32'h0000_0000);
  endtask

  // Powered off: interrupt flag wakes instead of the line
  task automatic t_powerdown();
    pwrReq <= 1'b0;
    wb(1'b1, OFS_MASK, 32'h0000_C000);
    wb(1'b1, OFS_FORCE, 32'h0000_8000);
    wt(4);
    `CHK(wake, 1'b1)
    `CHK(intLineN, 1'b1)
    pwrReq <= 1'b1;
  endtask

  // Bus reset pin keeps flags and masks, drops enables
  task automatic t_busreset();
    wb(1'b1, OFS_FORCE, 32'h0000_0010);
    wb(1'b1, OFS_MASK, 32'h0000_C010);
    rstReq <= 1'b1;
    wt(1);
    rstReq <= 1'b0;
    wt(8);
    rd(OFS_MASK, 32'h0000_0000);
    wb(1'b1, OFS_CONFIG, 32'h0000_000A);
    rd(OFS_EVENT, 32'h0000_8010);
    rd(OFS_MASK, 32'h0000_C010);
  endtask

  // Watchdog
  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_enable();
    t_function_interrupt_flag();
    t_general_wakeup_flag();
    t_present();
    t_powerdown();
    t_busreset();
    report_and_stop();
  end
endmodule // tb_cardbus_function_event_logic
